// file: pkg/bfr_pkg.sv
// package: offsets, field positions, reset values for the fault/revision regs
package bfr_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [7:0] FAULT_IND_ADDR = 8'hb0;
  localparam logic [7:0] SILICON_REV_ADDR = 8'hff;
  localparam int FAULT_BIT = 0;
  localparam logic FAULT_RESET = 1'h0;
  // arbitrary neutral revision code, not tied to any real part
  localparam logic [7:0] SILICON_REV_DEFAULT = 8'h5a;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bfr_req_s;

endpackage : bfr_pkg

// file: src/bfr_strap.sv
// strap sampler: latches single-ended mode once after reset release
`timescale 1ns/1ps
module bfr_strap
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // strap pins (low = tied to ground)
  input wire logic i_video_neg_pin,
  input wire logic i_video_common_mode_pin,
  // latched mode
  output logic o_single_ended
);

  logic taken_q;
  logic taken_d;
  logic se_q;
  logic se_d;

  // sample on first edge after release; async reset loads constants only
  always_comb
  begin
    taken_d = 1'b1;
    se_d = se_q;
    if (!taken_q)
    begin
      se_d = !i_video_neg_pin && !i_video_common_mode_pin; // [R6]
    end
  end

  // registers only; the comb above decides what is kept
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      taken_q <= 1'b0;
      se_q <= 1'b0;
    end
    else
    begin
      taken_q <= taken_d;
      se_q <= se_d;
    end
  end

  assign o_single_ended = se_q;

  // once latched, the mode holds until the next reset
  AST_STRAP_HOLD: assert property ( // [R6]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    $past(taken_q) |-> $stable(se_q))
    else $error("single-ended mode changed after latch");

endmodule : bfr_strap

// file: src/bfr_regs.sv
// bus-fault flag and silicon revision registers with output-mode strap
`timescale 1ns/1ps
// Summary of operation
// [R1] set fault bit 0 on unserviced access
// [R2] faulted read data is unreliable
// [R3] faulted write may be discarded
// [R4] reading fault register clears the flag
// [R5] read-only revision at top address
// [R6] both strap pins low latch single-ended
// [R7] upper bits zero, writes have no effect
//
// interface notes
// - a read is taken on the rising edge where i_req.rd is high;
//   o_rvalid follows one cycle later and stands for one cycle only
// - o_rdata keeps the last answer until the next read is taken, so a
//   slow host may pick it up late without losing it
// - unmapped addresses answer 8'h00, which keeps stray probes harmless
// - writes are accepted and dropped, as nothing in this group is
//   writable; o_wr_discard only tells upstream that a write met a fault
// - a failure pulse and a clearing read in one cycle leave the flag set:
//   the read returns the old value and the new fault waits for the next
//   read, so no failure is ever lost between two polls
// - the strap pins are looked at once, on the first edge after reset
//   leaves; moving them later has no effect until the next reset
// - limitation: the flag is one bit, so several failures between two
//   reads show up as one
module bfr_regs
#(
  parameter logic [7:0] REV_CODE = bfr_pkg::SILICON_REV_DEFAULT
)
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset_n,
  // register access from the serial slave
  input wire bfr_pkg::bfr_req_s i_req,
  input wire logic i_service_fail,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic o_wr_discard,
  // strap pins and mode
  input wire logic i_video_neg_pin,
  input wire logic i_video_common_mode_pin,
  output logic o_single_ended,
  output logic o_drive_neg_en
);

  // ****************************************
  // state
  // ****************************************
  logic fault_q;
  logic fault_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic se;

  // address decode used by both read mux and clear
  function automatic logic is_fault(input logic [7:0] a);
    return a == bfr_pkg::FAULT_IND_ADDR;
  endfunction : is_fault

  // ****************************************
  // fault flag
  // ****************************************
  // flag: a new fault wins over a read clear so no event is lost
  always_comb
  begin
    fault_d = fault_q;
    if (i_req.rd && is_fault(i_req.addr))
    begin
      fault_d = 1'b0; // [R4]
    end
    if (i_service_fail)
    begin
      fault_d = 1'b1; // [R1]
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // read mux; faulted reads still answer, data flagged unreliable upstream
  always_comb
  begin
    rvalid_d = i_req.rd;
    rdata_d = rdata_q;
    if (i_req.rd)
    begin
      if (is_fault(i_req.addr))
      begin
        rdata_d = 8'h00; // [R7]
        rdata_d[bfr_pkg::FAULT_BIT] = fault_q;
      end
      else if (i_req.addr == bfr_pkg::SILICON_REV_ADDR)
      begin
        rdata_d = REV_CODE; // [R5]
      end
      else
      begin
        rdata_d = 8'h00;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  // async reset loads constants only; next values come from the combs
  always_ff @(posedge i_core_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      fault_q <= bfr_pkg::FAULT_RESET;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      fault_q <= fault_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // writes to this group are never stored; faulted writes reported dropped
  assign o_wr_discard = i_req.wr && i_service_fail; // [R3]
  assign o_rdata = rdata_q; // [R2]
  assign o_rvalid = rvalid_q;

  // ****************************************
  // output mode strap
  // ****************************************
  bfr_strap u_strap
  (
    .i_core_clk(i_core_clk),
    .i_reset_n(i_reset_n),
    .i_video_neg_pin(i_video_neg_pin),
    .i_video_common_mode_pin(i_video_common_mode_pin),
    .o_single_ended(se)
  );

  assign o_single_ended = se;
  assign o_drive_neg_en = !se; // [R6]

  // ****************************************
  // checks: fault flag
  // ****************************************
  // a failure pulse always leaves the flag set on the next edge
  AST_FAULT_SET: assert property ( // [R1]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_service_fail |=> fault_q)
    else $error("fault flag not set");
  // a clean read of the flag register clears it
  AST_FAULT_CLR: assert property ( // [R4]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_req.rd && is_fault(i_req.addr) && !i_service_fail |=> !fault_q)
    else $error("fault flag not cleared by read");
  // the flag never rises on its own
  AST_NO_SPUR: assert property ( // [R1]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !fault_q && !i_service_fail |=> !fault_q)
    else $error("fault flag set without cause");
  // writes leave the flag alone
  AST_WR_IGNORE: assert property ( // [R7]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_req.wr && !i_req.rd && !i_service_fail
    |=> fault_q == $past(fault_q))
    else $error("write altered fault flag");

  // ****************************************
  // checks: read answers
  // ****************************************
  // flag register reads bit 0 with all upper bits clear
  AST_FAULT_RD: assert property ( // [R7]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_req.rd && is_fault(i_req.addr)
    |=> o_rvalid && o_rdata == {7'h00, $past(fault_q)})
    else $error("fault register read wrong");
  // revision register always answers its fixed code
  AST_REV_RD: assert property ( // [R5]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_req.rd && i_req.addr == bfr_pkg::SILICON_REV_ADDR
    |=> o_rdata == REV_CODE)
    else $error("revision read wrong");
  // a read that meets a failure still gets its answer strobe
  AST_FAULT_RD_ANSWER: assert property ( // [R2]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_req.rd && i_service_fail |=> o_rvalid)
    else $error("faulted read got no answer");
  // no answer strobe without a read
  AST_NO_IDLE_VALID: assert property ( // [R2]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !i_req.rd |=> !o_rvalid)
    else $error("answer strobe without read");
  // answer data holds between reads
  AST_RDATA_HOLD: assert property ( // [R2]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !i_req.rd |=> $stable(o_rdata))
    else $error("read data moved without read");

  // ****************************************
  // checks: writes and output mode
  // ****************************************
  // discard is reported only when a write meets a failure
  AST_DISCARD: assert property ( // [R3]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    o_wr_discard |-> i_service_fail)
    else $error("discard without fault");
  // and every write that meets a failure is reported
  AST_DISCARD_ON_FAULT: assert property ( // [R3]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    i_req.wr && i_service_fail |-> o_wr_discard)
    else $error("faulted write not reported");
  // single-ended mode silences the negative output
  AST_NEG_DRIVE: assert property ( // [R6]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    o_single_ended |-> !o_drive_neg_en)
    else $error("negative output driven in single-ended mode");
  // differential mode keeps the negative output driven
  AST_NEG_DRIVE_DIFF: assert property ( // [R6]
    @(posedge i_core_clk) disable iff (!i_reset_n)
    !o_single_ended |-> o_drive_neg_en)
    else $error("negative output idle in differential mode");

  // ****************************************
  // covers
  // ****************************************
  COV_FAULT: cover property (@(posedge i_core_clk) i_service_fail);
  COV_CLR: cover property (@(posedge i_core_clk)
    fault_q ##1 (i_req.rd && is_fault(i_req.addr)) ##1 !fault_q);
  COV_REV: cover property (@(posedge i_core_clk)
    i_req.rd && i_req.addr == bfr_pkg::SILICON_REV_ADDR);
  COV_SE: cover property (@(posedge i_core_clk) o_single_ended);
  // a failure that lands on the clearing read
  COV_SET_ON_CLR: cover property (@(posedge i_core_clk)
    i_service_fail && i_req.rd && is_fault(i_req.addr));

endmodule : bfr_regs

// file: bench/bfr_host.sv
// host model: issues single-byte register accesses
`timescale 1ns/1ps
module bfr_host
(
  // clock
  input wire logic i_core_clk,
  // request to the block
  output bfr_pkg::bfr_req_s o_req
);
  initial o_req = '0;
  // one access raised after a falling edge, dropped after one rising edge
  task automatic acc(input logic w, input logic [7:0] a);
    @(negedge i_core_clk);
    o_req = '{rd: !w, wr: w, addr: a, wdata: 8'hff};
    @(negedge i_core_clk);
    o_req = '0;
  endtask : acc
endmodule : bfr_host

// file: bench/tb.sv
// testbench: fault flag, revision and strap checks
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic fail = 1'b0;
  logic neg_pin = 1'b0;
  logic cm_pin = 1'b0;
  logic [7:0] rdata;
  logic rvalid, wr_discard, se, neg_en;
  bfr_pkg::bfr_req_s req;
  int n_fail = 0;
  int n_tests = 0;
  always #4 clk = ~clk;
  bfr_host i_bfr_host (.i_core_clk(clk), .o_req(req));
  bfr_regs i_bfr_regs (.i_core_clk(clk), .i_reset_n(rst_n), .i_req(req),
    .i_service_fail(fail), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_wr_discard(wr_discard), .i_video_neg_pin(neg_pin),
    .i_video_common_mode_pin(cm_pin), .o_single_ended(se),
    .o_drive_neg_en(neg_en));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // answer stands one cycle only, so judge it at the next falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_bfr_host.acc(1'b0, a);
    chk({7'h0, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask : rd
  // straps held through reset and the first edge after release
  task automatic do_reset(input logic [1:0] s);
    rst_n = 1'b0;
    neg_pin = s[1];
    cm_pin = s[0];
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : do_reset
  // fault pulse; discard must follow only a coinciding write
  task automatic pulse(input logic expd);
    @(negedge clk);
    fail = 1'b1;
    #1;
    chk({7'h0, wr_discard}, {7'h0, expd});
    @(negedge clk);
    fail = 1'b0;
  endtask : pulse
  task automatic t_strap;
    for (int i = 0; i < 4; i++)
    begin
      do_reset(2'(i));
      chk({7'h0, se}, {7'h0, i == 0});
      chk({7'h0, neg_en}, {7'h0, i != 0});
      // pins moved after the latch must not change the mode
      neg_pin = ~neg_pin;
      cm_pin = ~cm_pin;
      @(negedge clk);
      chk({7'h0, se}, {7'h0, i == 0});
    end
  endtask : t_strap
  task automatic t_regs;
    rd(8'hb0, 8'h00);
    rd(8'hff, bfr_pkg::SILICON_REV_DEFAULT);
    rd(8'h11, 8'h00);
    i_bfr_host.acc(1'b1, 8'hff);
    chk({7'h0, rvalid}, 8'h00);
    rd(8'hff, bfr_pkg::SILICON_REV_DEFAULT);
    i_bfr_host.acc(1'b1, 8'hb0);
    rd(8'hb0, 8'h00);
  endtask : t_regs
  task automatic t_fault;
    pulse(1'b0);
    rd(8'hb0, 8'h01);
    rd(8'hb0, 8'h00);
    fork
      i_bfr_host.acc(1'b1, 8'hb0);
      pulse(1'b1);
    join
    rd(8'hb0, 8'h01);
    // a fault on the clearing read must survive the clear
    fork
      rd(8'hb0, 8'h00);
      pulse(1'b0);
    join
    rd(8'hb0, 8'h01);
    rd(8'hb0, 8'h00);
  endtask : t_fault
  task automatic results;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  initial
  begin
    t_strap();
    t_regs();
    t_fault();
    results();
  end
endmodule : tb
